// File: tlb_regs_pkg.sv
package tlb_regs_pkg;

    // ==========================================================================
    // Register numbers and sizes.
    // ==========================================================================
    localparam logic [4:0] REG_ENTRY_SELECT    = 5'h00;
    localparam logic [4:0] REG_REPLACEMENT     = 5'h01;
    localparam logic [4:0] REG_EVEN_PAGE       = 5'h02;
    localparam logic [4:0] REG_ODD_PAGE        = 5'h03;
    localparam logic [4:0] REG_PAGE_TABLE      = 5'h04;
    localparam logic [4:0] REG_PAGE_SIZE       = 5'h05;
    localparam logic [4:0] REG_FIXED_BOUNDARY  = 5'h06;

    localparam int          IDX_W              = 6;
    localparam logic [5:0]  TLB_TOP            = 6'h3f;
    localparam logic [5:0]  FIXED_RESET        = 6'h00;

    // ==========================================================================
    // Field positions.
    // ==========================================================================
    localparam int PROBE_FAIL_POS   = 31;
    localparam int NO_EXEC_POS      = 61;
    localparam int FRAME_HI         = 33;
    localparam int FRAME_LO         = 6;
    localparam int UNCACHED_HI      = 63;
    localparam int UNCACHED_LO      = 62;
    localparam int WRITABLE_POS     = 2;
    localparam int VALID_POS        = 1;
    localparam int GLOBAL_POS       = 0;
    localparam int PAIR_HI          = 22;
    localparam int PAIR_LO          = 4;
    localparam int MASK_HI          = 24;
    localparam int MASK_LO          = 13;
    localparam int SYS_ADDR_DATA_BUS_UC_HI      = 59;
    localparam int SYS_ADDR_DATA_BUS_UC_LO      = 58;
    localparam int KSU_HI           = 4;
    localparam int KSU_LO           = 3;

    // Writable bits of each register; all others are reserved and read zero, except page table bits 22:4, which hold the faulting page pair.
    localparam logic [63:0] PAGE_WMASK   = 64'he000_0003_ffff_ffff;
    localparam logic [63:0] PTR_WMASK    = 64'hffff_ffff_ff80_0000;
    localparam logic [31:0] SIZE_WMASK   = 32'h01ff_e000;
    localparam logic [63:0] PAGE_RESET   = 64'h0;

    // ==========================================================================
    // Carriers.
    // ==========================================================================
    typedef struct packed {
        logic       valid;
        logic       write;
        logic       wide;
        logic [4:0] regno;
        logic [63:0] wdata;
    } cop_req_t;

    typedef struct packed {
        logic [1:0]  uncached;
        logic        no_exec;
        logic [27:0] frame;
        logic [2:0]  coherence;
        logic        writable;
        logic        valid;
    } page_half_t;

    typedef struct packed {
        page_half_t  even;
        page_half_t  odd;
        logic        global_bit;
        logic [11:0] size_mask;
    } tlb_lo_t;

    typedef struct packed {
        logic        hit;
        logic [5:0]  index;
        tlb_lo_t     entry;
    } probe_res_t;

    typedef enum logic [1:0] {
        ACC_LOAD,
        ACC_STORE,
        ACC_FETCH
    } access_t;

endpackage : tlb_regs_pkg

// File: tlb_replace_ctr.sv
`timescale 1ns/1ps
`default_nettype none

module tlb_replace_ctr (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_graduate,
    input  wire logic       i_reload,
    input  wire logic [5:0] i_floor,
    output logic      [5:0] o_value
);
    import tlb_regs_pkg::*;

    typedef struct packed {
        logic [5:0] value;
    } ctr_state_t;

    ctr_state_t state_q;
    ctr_state_t state_d;

    always_comb begin
        state_d = state_q;
        if (i_reload) begin
            state_d.value = TLB_TOP;
        end else if (i_graduate) begin
            // Wrapping at the floor keeps fixed entries out of reach.
            if (state_q.value <= i_floor) begin
                state_d.value = TLB_TOP;
            end else begin
                state_d.value = state_q.value - 6'h01;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q.value <= TLB_TOP;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_value = state_q.value;

endmodule : tlb_replace_ctr

`default_nettype wire

// File: tlb_attr_check.sv
`timescale 1ns/1ps
`default_nettype none

module tlb_attr_check (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_lookup,
    input  wire logic                    i_odd,
    input  wire tlb_regs_pkg::access_t   i_access,
    input  wire tlb_regs_pkg::probe_res_t i_match,
    output logic                         o_load_invalid_exc,
    output logic                         o_store_invalid_exc,
    output logic                         o_exec_denied,
    output logic                         o_write_denied,
    output logic                         o_miss,
    output logic [1:0]                   o_uncached
);
    import tlb_regs_pkg::*;

    typedef struct packed {
        logic       load_inv;
        logic       store_inv;
        logic       exec_den;
        logic       write_den;
        logic       miss;
        logic [1:0] uncached;
    } chk_state_t;

    chk_state_t state_q;
    chk_state_t state_d;
    page_half_t half;

    always_comb begin
        half    = i_odd ? i_match.entry.odd : i_match.entry.even;
        state_d = '0;
        state_d.uncached = state_q.uncached;
        if (i_lookup) begin
            if (!i_match.hit) begin
                state_d.miss = 1'b1;
            end else if (!half.valid) begin
                state_d.load_inv  = (i_access != ACC_STORE);
                state_d.store_inv = (i_access == ACC_STORE);
            end else begin
                state_d.exec_den  = (i_access == ACC_FETCH) && half.no_exec;
                state_d.write_den = (i_access == ACC_STORE) && !half.writable;
                state_d.uncached  = half.uncached;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_load_invalid_exc  = state_q.load_inv;
    assign o_store_invalid_exc = state_q.store_inv;
    assign o_exec_denied       = state_q.exec_den;
    assign o_write_denied      = state_q.write_den;
    assign o_miss              = state_q.miss;
    assign o_uncached          = state_q.uncached;

endmodule : tlb_attr_check

`default_nettype wire

// File: tlb_management_regs.sv
// Overview of operation
// - Index register is 32 bits: six-bit entry field, probe fail flag on top.
// - Probe fail flag becomes 1 when the last probe found no match.
// - Index field picks the entry for indexed reads and indexed writes.
// - Reserved fields are written as zero by software and always read zero.
// - Replacement pointer is read-only, six bits, decrements each graduating cycle.
// - Replacement pointer stays between the fixed boundary and entry count minus one.
// - Random writes use the current replacement pointer as their target entry.
// - Reset loads the replacement pointer with the top entry.
// - Writing the fixed boundary register reloads the replacement pointer to top.
// - Even and odd page frame registers share one format, feed TLB reads, writes.
// - Page fields: no-execute 61, frame 33:6, coherence 5:3, writable 2, valid 1, global 0.
// - Uncached bits 63:62 go into the TLB and out on bus bits 59:58.
// - Only the low 32 bits are visible in 32-bit user and supervisor modes.
// - No-execute bit set makes the page non-executable.
// - Stores are permitted only when the writable bit is set.
// - Matching entry with valid clear raises load or store invalid exception.
// - One global bit per entry, set when both halves have bit 0 set.
// - Software writes page bits 33:31 only as all zeroes or all ones.
// - A miss stores virtual address bits 31:13 in the faulting page pair field.
// - Page size mask bits exclude address bits 24:13 from comparison.
// - Entries below the fixed boundary are never chosen for replacement.
// - Reset clears the fixed boundary register to zero.
// - Access is allowed in kernel mode or with coprocessor-0 usable, else exception.
`timescale 1ns/1ps
`default_nettype none

module tlb_management_regs (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_n,
    // Coprocessor move port.
    input  wire tlb_regs_pkg::cop_req_t   i_req,
    input  wire logic                     i_kernel_mode,
    input  wire logic                     i_cu0_usable,
    input  wire logic [1:0]               i_ksu,
    input  wire logic                     i_addr64_enable,
    output logic [63:0]                   o_rdata,
    output logic                          o_rvalid,
    output logic                          o_cop_unusable_exc,
    // Pipeline events.
    input  wire logic                     i_graduate,
    input  wire logic                     i_probe_done,
    input  wire tlb_regs_pkg::probe_res_t i_probe_res,
    input  wire logic                     i_read_done,
    input  wire tlb_regs_pkg::tlb_lo_t    i_read_entry,
    input  wire logic                     i_tlb_miss,
    input  wire logic [31:0]              i_miss_vaddr,
    // Translation check.
    input  wire logic                     i_lookup,
    input  wire logic                     i_lookup_odd,
    input  wire tlb_regs_pkg::access_t    i_access,
    input  wire tlb_regs_pkg::probe_res_t i_lookup_res,
    input  wire logic                     i_uncached_addr_cycle,
    // TLB array side.
    input  wire logic                     i_indexed_write_cmd,
    input  wire logic                     i_random_write_cmd,
    input  wire logic                     i_indexed_read_cmd,
    output logic                          o_tlb_write,
    output logic                          o_tlb_read,
    output logic [5:0]                    o_tlb_index,
    output tlb_regs_pkg::tlb_lo_t         o_tlb_wentry,
    output logic [11:0]                   o_compare_mask,
    output logic [1:0]                    o_sys_addr_data_uc,
    output logic                          o_load_invalid_exc,
    output logic                          o_store_invalid_exc,
    output logic                          o_exec_denied,
    output logic                          o_write_denied
);
    import tlb_regs_pkg::*;

    // ==========================================================================
    // State.
    // ==========================================================================
    typedef struct packed {
        logic        probe_fail;
        logic [5:0]  entry_index;
        logic [63:0] even_page;
        logic [63:0] odd_page;
        logic [40:0] table_base;
        logic [18:0] fault_pair;
        logic [11:0] size_mask;
        logic [5:0]  fixed_bound;
        logic [63:0] rdata;
        logic        rvalid;
        logic        unusable;
        logic        twrite;
        logic        tread;
        logic [5:0]  tindex;
        tlb_lo_t     wentry;
    } regs_state_t;

    regs_state_t state_q;
    regs_state_t state_d;

    logic        allowed;
    logic        narrow;
    logic        wr_en;
    logic        fixed_wr;
    logic [63:0] rd_word;
    logic [63:0] wval;
    logic [5:0]  repl_value;
    logic        check_miss;
    logic [1:0]  lookup_uc;

    // ==========================================================================
    // Access gating.
    // ==========================================================================
    assign allowed  = i_kernel_mode || i_cu0_usable;
    // 32-bit user or supervisor mode hides the upper halves.
    assign narrow   = !i_kernel_mode && !i_addr64_enable
                      && (i_ksu != 2'b00);
    assign wr_en    = i_req.valid && i_req.write && allowed;
    assign fixed_wr = wr_en && (i_req.regno == REG_FIXED_BOUNDARY);

    // Narrow writes sign-extend the low word, as the integer file does.
    assign wval = (narrow || !i_req.wide) ? {{32{i_req.wdata[31]}}, i_req.wdata[31:0]}
                                          : i_req.wdata;

    function automatic tlb_lo_t pack_entry(input logic [63:0] ev, input logic [63:0] od,
                                           input logic [11:0] msk);
        tlb_lo_t e;
        e.even           = {ev[UNCACHED_HI:NO_EXEC_POS], ev[FRAME_HI:VALID_POS]};
        e.odd            = {od[UNCACHED_HI:NO_EXEC_POS], od[FRAME_HI:VALID_POS]};
        e.global_bit     = ev[GLOBAL_POS] & od[GLOBAL_POS];
        e.size_mask      = msk;
        return e;
    endfunction : pack_entry

    function automatic logic [63:0] unpack_half(input page_half_t h, input logic g);
        return {h.uncached, h.no_exec, 27'h0, h.frame, h.coherence, h.writable, h.valid, g};
    endfunction : unpack_half

    // ==========================================================================
    // Read multiplexer.
    // ==========================================================================
    always_comb begin
        rd_word = '0;
        if (i_req.regno == REG_ENTRY_SELECT) begin
            rd_word[PROBE_FAIL_POS] = state_q.probe_fail;
            rd_word[5:0]            = state_q.entry_index;
            rd_word[63:32]          = {32{state_q.probe_fail}};
        end else if (i_req.regno == REG_REPLACEMENT) begin
            rd_word[5:0] = repl_value;
        end else if (i_req.regno == REG_EVEN_PAGE) begin
            rd_word = state_q.even_page;
        end else if (i_req.regno == REG_ODD_PAGE) begin
            rd_word = state_q.odd_page;
        end else if (i_req.regno == REG_PAGE_TABLE) begin
            rd_word = {state_q.table_base, state_q.fault_pair, 4'h0};
        end else if (i_req.regno == REG_PAGE_SIZE) begin
            rd_word[MASK_HI:MASK_LO] = state_q.size_mask;
        end else if (i_req.regno == REG_FIXED_BOUNDARY) begin
            rd_word[5:0] = state_q.fixed_bound;
        end
        if (narrow || !i_req.wide) begin
            rd_word[63:32] = {32{rd_word[31]}};
        end
    end

    // ==========================================================================
    // Register update.
    // ==========================================================================
    always_comb begin
        state_d          = state_q;
        state_d.rvalid   = i_req.valid && !i_req.write && allowed;
        state_d.unusable = i_req.valid && !allowed;
        state_d.twrite   = 1'b0;
        state_d.tread    = 1'b0;
        if (i_req.valid && !i_req.write && allowed) begin
            state_d.rdata = rd_word;
        end
        if (wr_en) begin
            if (i_req.regno == REG_ENTRY_SELECT) begin
                state_d.entry_index = wval[5:0];
            end else if (i_req.regno == REG_EVEN_PAGE) begin
                state_d.even_page = wval & PAGE_WMASK;
            end else if (i_req.regno == REG_ODD_PAGE) begin
                state_d.odd_page = wval & PAGE_WMASK;
            end else if (i_req.regno == REG_PAGE_TABLE) begin
                state_d.table_base = wval[63:23];
            end else if (i_req.regno == REG_PAGE_SIZE) begin
                state_d.size_mask = wval[MASK_HI:MASK_LO];
            end else if (i_req.regno == REG_FIXED_BOUNDARY) begin
                state_d.fixed_bound = wval[5:0];
            end
        end
        // Hardware events land after software writes so that they win.
        if (i_probe_done) begin
            state_d.probe_fail = !i_probe_res.hit;
            if (i_probe_res.hit) begin
                state_d.entry_index = i_probe_res.index;
            end
        end
        if (i_read_done) begin
            state_d.even_page = unpack_half(i_read_entry.even, i_read_entry.global_bit);
            state_d.odd_page  = unpack_half(i_read_entry.odd, i_read_entry.global_bit);
            state_d.size_mask = i_read_entry.size_mask;
        end
        if (i_tlb_miss) begin
            state_d.fault_pair = i_miss_vaddr[31:13];
        end
        if (i_indexed_write_cmd || i_random_write_cmd) begin
            state_d.twrite = 1'b1;
            state_d.wentry = pack_entry(state_q.even_page, state_q.odd_page,
                                        state_q.size_mask);
            // Random writes take the live pointer, which never sits below the boundary.
            state_d.tindex = i_random_write_cmd ? repl_value
                                                : state_q.entry_index;
        end else if (i_indexed_read_cmd) begin
            state_d.tread  = 1'b1;
            state_d.tindex = state_q.entry_index;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q             <= '0;
            state_q.even_page   <= PAGE_RESET;
            state_q.odd_page    <= PAGE_RESET;
            state_q.fixed_bound <= FIXED_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================================
    // Submodules.
    // ==========================================================================
    tlb_replace_ctr u_replace (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_graduate (i_graduate),
        .i_reload   (fixed_wr),
        .i_floor    (state_q.fixed_bound),
        .o_value    (repl_value)
    );

    tlb_attr_check u_check (
        .i_clk               (i_clk),
        .i_rst_n             (i_rst_n),
        .i_lookup            (i_lookup),
        .i_odd               (i_lookup_odd),
        .i_access            (i_access),
        .i_match             (i_lookup_res),
        .o_load_invalid_exc  (o_load_invalid_exc),
        .o_store_invalid_exc (o_store_invalid_exc),
        .o_exec_denied       (o_exec_denied),
        .o_write_denied      (o_write_denied),
        .o_miss              (check_miss),
        .o_uncached          (lookup_uc)
    );

    // ==========================================================================
    // Outputs.
    // ==========================================================================
    assign o_rdata            = state_q.rdata;
    assign o_rvalid           = state_q.rvalid;
    assign o_cop_unusable_exc = state_q.unusable;
    assign o_tlb_write        = state_q.twrite;
    assign o_tlb_read         = state_q.tread;
    assign o_tlb_index        = state_q.tindex;
    assign o_tlb_wentry       = state_q.wentry;
    // Mask of ones drops those address bits from the tag compare.
    assign o_compare_mask     = state_q.size_mask;
    // A lookup miss drives zeroes in place of stale uncached bits.
    assign o_sys_addr_data_uc = (i_uncached_addr_cycle && !check_miss) ? lookup_uc
                                                                       : 2'b00;

endmodule : tlb_management_regs

`default_nettype wire

// File: tlb_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port checker.
module tlb_regs_asserts
    import tlb_regs_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire cop_req_t   i_req,
    input wire logic       i_kernel_mode,
    input wire logic       i_cu0_usable,
    input wire logic [63:0] o_rdata,
    input wire logic       o_rvalid,
    input wire logic       o_cop_unusable_exc,
    input wire logic       i_lookup,
    input wire logic       i_lookup_odd,
    input wire access_t    i_access,
    input wire probe_res_t i_lookup_res,
    input wire logic       i_uncached_addr_cycle,
    input wire logic       i_indexed_write_cmd,
    input wire logic       o_tlb_write,
    input wire logic [1:0] o_sys_addr_data_uc,
    input wire logic       o_load_invalid_exc,
    input wire logic       o_store_invalid_exc,
    input wire logic       o_exec_denied,
    input wire logic       o_write_denied
);
    page_half_t half;
    logic       hv;
    assign half = i_lookup_odd ? i_lookup_res.entry.odd : i_lookup_res.entry.even;
    assign hv = i_lookup && i_lookup_res.hit;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    unusable_exc_a: assert property (i_req.valid && !i_kernel_mode && !i_cu0_usable |=> o_cop_unusable_exc && !o_rvalid)
        else $error("refused request without unusable exception");
    read_answer_a: assert property (i_req.valid && !i_req.write && (i_kernel_mode || i_cu0_usable) |=> o_rvalid)
        else $error("allowed read without answer");
    index_write_a: assert property (i_indexed_write_cmd |=> o_tlb_write)
        else $error("indexed write not issued");
    pointer_read_a: assert property (o_rvalid && $past(i_req.regno) == REG_REPLACEMENT |-> o_rdata[63:6] == 58'h0)
        else $error("pointer read shows reserved bits");
    load_invalid_a: assert property (hv && !half.valid && i_access != ACC_STORE |=> o_load_invalid_exc)
        else $error("invalid load not flagged");
    store_invalid_a: assert property (hv && !half.valid && i_access == ACC_STORE |=> o_store_invalid_exc)
        else $error("invalid store not flagged");
    miss_quiet_a: assert property (i_lookup && !i_lookup_res.hit |=> !o_load_invalid_exc && !o_store_invalid_exc)
        else $error("exception on lookup miss");
    exec_deny_a: assert property (hv && half.valid && i_access == ACC_FETCH |=> o_exec_denied == $past(half.no_exec))
        else $error("execute permission wrong");
    write_deny_a: assert property (hv && half.valid && i_access == ACC_STORE |=> o_write_denied != $past(half.writable))
        else $error("write permission wrong");
    uc_gate_a: assert property (!i_uncached_addr_cycle |-> o_sys_addr_data_uc == 2'b00)
        else $error("uncached bits outside address cycle");
endmodule : tlb_regs_asserts
bind tlb_management_regs tlb_regs_asserts chk (.*);
`default_nettype wire

// File: test_tlb_management_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_tlb_management_regs;
    import tlb_regs_pkg::*;
    logic i_clk, i_rst_n, i_kernel_mode, i_cu0_usable, i_addr64_enable, i_graduate, i_probe_done, i_read_done;
    logic i_tlb_miss, i_lookup, i_lookup_odd, i_uncached_addr_cycle, i_indexed_write_cmd, i_random_write_cmd;
    logic i_indexed_read_cmd, o_rvalid, o_cop_unusable_exc, o_tlb_write, o_tlb_read, o_load_invalid_exc;
    logic o_store_invalid_exc, o_exec_denied, o_write_denied;
    logic [1:0] i_ksu, o_sys_addr_data_uc;
    logic [5:0] o_tlb_index;
    logic [11:0] o_compare_mask, m;
    logic [31:0] i_miss_vaddr;
    logic [63:0] o_rdata, rd;
    cop_req_t i_req;
    access_t i_access;
    probe_res_t i_probe_res, i_lookup_res;
    tlb_lo_t i_read_entry, o_tlb_wentry;
    int error_cnt, samples_checked;
    tlb_management_regs dut (.*);
    initial begin
        i_clk = 0;
        forever #12.5 i_clk = ~i_clk;
    end
    // ============================================================
    // Shared tasks.
    task automatic step();
        @(posedge i_clk);
        #2;
    endtask : step
    task automatic pulse(ref logic s);
        s = 1;
        step();
        s = 0;
    endtask : pulse
    task automatic chk(input string nm, input logic [63:0] e, g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One move and one idle cycle.
    task automatic cop(input logic w, wd, input logic [4:0] r, input logic [63:0] d);
        logic ok;
        ok = i_kernel_mode || i_cu0_usable;
        i_req = '{1'b1, w, wd, r, d};
        step();
        rd = o_rdata;
        chk("answer", {62'h0, ok & !w, !ok}, {62'h0, o_rvalid, o_cop_unusable_exc});
        i_req.valid = 1'b0;
        step();
    endtask : cop
    task automatic look(input access_t a, input logic od, h, v, wr, nx, input logic [3:0] e);
        i_lookup_res = '0;
        i_lookup_res.hit = h;
        i_lookup_res.entry.even = '{2'b11, nx, 28'h0, 3'h2, wr, v};
        i_lookup_res.entry.odd = i_lookup_res.entry.even;
        i_access = a;
        {i_lookup_odd, i_lookup, i_uncached_addr_cycle} = {od, 2'b11};
        step();
        i_lookup = 0;
        chk("lookup", e, {o_load_invalid_exc, o_store_invalid_exc, o_exec_denied, o_write_denied});
        chk("uncached", {2{h & v}}, o_sys_addr_data_uc);
        i_uncached_addr_cycle = 0;
        step();
    endtask : look
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    // ============================================================
    // Scenarios.
    task automatic replace_walk();
        cop(0, 0, REG_FIXED_BOUNDARY, 0);
        chk("boundary", 0, rd);
        cop(0, 0, REG_REPLACEMENT, 0);
        chk("pointer", 64'h3f, rd);
        cop(1, 0, REG_FIXED_BOUNDARY, 64'h3c);
        i_graduate = 1;
        repeat (3) step();
        i_graduate = 0;
        cop(0, 0, REG_REPLACEMENT, 0);
        chk("pointer", 64'h3c, rd);
        pulse(i_random_write_cmd);
        chk("random", 7'h7c, {o_tlb_write, o_tlb_index});
        pulse(i_graduate);
        cop(1, 0, REG_REPLACEMENT, 64'h5);
        cop(0, 0, REG_REPLACEMENT, 0);
        chk("pointer", 64'h3f, rd);
    endtask : replace_walk
    task automatic page_regs();
        cop(1, 1, REG_EVEN_PAGE, '1);
        cop(0, 1, REG_EVEN_PAGE, 0);
        chk("even page", PAGE_WMASK, rd);
        {i_kernel_mode, i_cu0_usable, i_ksu, i_addr64_enable} = 5'b01100;
        cop(1, 1, REG_ODD_PAGE, 64'hc000_0000_8000_0005);
        cop(0, 1, REG_ODD_PAGE, 0);
        chk("narrow page", 64'hffff_ffff_8000_0005, rd);
        {i_kernel_mode, i_ksu, i_addr64_enable} = 4'b1001;
        cop(0, 1, REG_ODD_PAGE, 0);
        chk("odd page", 64'he000_0003_8000_0005, rd);
        cop(1, 0, REG_ENTRY_SELECT, 64'h25);
        for (int g = 1; g <= 2; g++) begin
            cop(1, 0, REG_EVEN_PAGE, 64'(g));
            pulse(i_indexed_write_cmd);
            chk("write", {1'b1, 6'h25, g == 1}, {o_tlb_write, o_tlb_index, o_tlb_wentry.global_bit});
        end
        pulse(i_indexed_read_cmd);
        chk("read", 7'h65, {o_tlb_read, o_tlb_index});
        i_read_entry.even = '{2'b10, 1'b1, 28'h1, 3'h3, 1'b1, 1'b0};
        pulse(i_read_done);
        cop(0, 1, REG_EVEN_PAGE, 0);
        chk("tlb read", 64'ha000_0000_0000_005c, rd);
    endtask : page_regs
    task automatic probe_miss_mask();
        for (int h = 0; h < 2; h++) begin
            i_probe_res = '{h[0], 6'h7, '0};
            pulse(i_probe_done);
            cop(0, 0, REG_ENTRY_SELECT, 0);
            chk("select", h ? 64'h7 : 64'hffff_ffff_8000_0025, rd);
        end
        cop(1, 1, REG_PAGE_TABLE, '1);
        i_miss_vaddr = 32'hdead_b000;
        pulse(i_tlb_miss);
        cop(0, 1, REG_PAGE_TABLE, 0);
        chk("table", PTR_WMASK | (64'(i_miss_vaddr[31:13]) << 4), rd);
        for (int k = 0; k < 7; k++) begin
            m = 12'((1 << (2 * k)) - 1);
            cop(1, 0, REG_PAGE_SIZE, {39'h0, m, 13'h0});
            chk("mask", m, o_compare_mask);
        end
        {i_kernel_mode, i_cu0_usable} = 2'b00;
        cop(1, 0, REG_FIXED_BOUNDARY, 64'h5);
        i_cu0_usable = 1;
        cop(0, 0, REG_FIXED_BOUNDARY, 0);
        chk("boundary", 64'h3c, rd);
        i_kernel_mode = 1;
    endtask : probe_miss_mask
    initial begin
        {i_rst_n, i_cu0_usable, i_graduate, i_probe_done, i_read_done, i_tlb_miss} = '0;
        {i_lookup, i_lookup_odd, i_uncached_addr_cycle, i_indexed_write_cmd, i_random_write_cmd} = '0;
        {i_ksu, i_addr64_enable, i_indexed_read_cmd, i_miss_vaddr, i_kernel_mode} = 37'h1;
        {i_req, i_probe_res, i_lookup_res, i_read_entry} = '0;
        i_access = ACC_LOAD;
        {error_cnt, samples_checked} = '0;
        repeat (6) @(posedge i_clk);
        #2 i_rst_n = 1;
        replace_walk();
        page_regs();
        probe_miss_mask();
        look(ACC_LOAD, 0, 1, 0, 1, 0, 4'b1000);
        look(ACC_STORE, 1, 1, 0, 1, 0, 4'b0100);
        look(ACC_FETCH, 0, 1, 1, 1, 1, 4'b0010);
        look(ACC_STORE, 1, 1, 1, 0, 0, 4'b0001);
        look(ACC_STORE, 0, 0, 0, 0, 1, 4'b0000);
        give_verdict();
    end
    // A stuck run counts as a mismatch.
    initial begin
        #50us;
        error_cnt++;
        give_verdict();
    end
endmodule : test_tlb_management_regs
`default_nettype wire
